// ==== sdi_sdram_core.sv ====
`timescale 1ns/100ps
`include "sdi_defines.svh"

// What this block does
// - all inputs sampled on rising clock only
// - four banks, 4096 rows, per-width column count
// - active takes bank lines and twelve row lines
// - read/write column lines depend on width variant
// - precharge all, then wait; banks go idle
// - mode undefined until loaded before operation
// - mode load needs bank lines zero; kept
// - data outputs high-impedance after mode load
// - mode fields: length, type, latency, mode, write
// - lengths 1,2,4,8; full page sequential only
// - length bounds columns per read or write
// - bursts wrap inside aligned block of length
// - full page wraps to row start
// - line 10 selects precharge all or one
// - active is cs, ras low, cas, we high
module sdi_sdram_core (
    // clock, reset, clock enable
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    clock_enable_input,
    // width variant strap, caught while reset is held
    input  wire sdi_pkg::sdi_org_t       org_strap,
    // command and address pins
    input  wire sdi_pkg::sdi_pins_t      pins,
    // array access, one beat a cycle
    output sdi_pkg::sdi_access_t         access,
    output logic                         dq_oe,
    // status
    output logic [`SDI_MODE_W-1:0]       mode_value,
    output logic [3:0]                   banks_open,
    output logic                         init_done
);
    sdi_pkg::sdi_state_t   s;
    sdi_pkg::sdi_state_t   next_s;
    sdi_pkg::sdi_cmd_t     cmd;
    logic                  rw_go;
    logic                  halt;
    logic                  wbm_single;
    logic                  new_full;
    logic [`SDI_COL_W-1:0] new_mask;
    logic [`SDI_COL_W-1:0] start_sel;
    logic [`SDI_COL_W-1:0] beat_sel;
    logic [`SDI_COL_W-1:0] mask_sel;
    logic                  full_sel;
    logic                  inter_sel;
    logic                  wr_sel;
    logic [`SDI_BANK_W-1:0] bank_sel;
    logic [`SDI_COL_W-1:0] beat_col;
    logic [2:0]            len_code;

    // command decode straight from the sampled pins
    assign cmd = sdi_pkg::sdi_decode(pins);
    assign len_code = s.mode[`SDI_M_LEN_HI:`SDI_M_LEN_LO];

    // a read or write only starts into an open row after init
    assign rw_go = (cmd == sdi_pkg::SDI_READ || cmd == sdi_pkg::SDI_WRITE)
                   && s.ist == sdi_pkg::SDI_READY
                   && s.open[pins.bank_select];

    // terminate, mode load, or precharge of the burst bank ends it
    assign halt = cmd == sdi_pkg::SDI_TERM
                  || cmd == sdi_pkg::SDI_LOAD_MODE
                  || (cmd == sdi_pkg::SDI_PRECHARGE
                      && (pins.address_lines[`SDI_PRE_ALL_BIT]
                          || pins.bank_select == s.b_bank));

    // write burst mode bit turns writes into single accesses
    assign wbm_single = cmd == sdi_pkg::SDI_WRITE && s.mode[`SDI_M_WBM];
    assign new_full = !wbm_single && len_code == `SDI_BLFULL;
    assign new_mask = wbm_single ? `SDI_MASK_BL1
                    : sdi_pkg::sdi_blk_mask(len_code, s.org);

    // beat source: new command or the running burst
    assign start_sel = rw_go
                     ? sdi_pkg::sdi_col_of(pins.address_lines, s.org)
                     : s.b_start;
    assign beat_sel  = rw_go ? 11'h000 : s.b_cnt;
    assign mask_sel  = rw_go ? new_mask : s.b_mask;
    assign full_sel  = rw_go ? new_full : s.b_full;
    // interleave is never used with full page
    assign inter_sel = rw_go ? (s.mode[`SDI_M_TYPE] && !new_full)
                             : s.b_inter;
    assign wr_sel    = rw_go ? (cmd == sdi_pkg::SDI_WRITE) : s.b_wr;
    assign bank_sel  = rw_go ? pins.bank_select : s.b_bank;

    sdi_burst_col u_col (
        .start (start_sel),
        .beat  (beat_sel),
        .mask  (mask_sel),
        .inter (inter_sel),
        .col   (beat_col)
    );

    // next state of the whole device
    always_comb begin
        next_s = s;
        next_s.acc.rd = 1'b0;
        next_s.acc.wr = 1'b0;
        case (cmd)
            sdi_pkg::SDI_ACTIVE: begin
                // row tracking for each of the four banks
                if (s.ist == sdi_pkg::SDI_READY) begin
                    next_s.open[pins.bank_select] = 1'b1;
                    next_s.row[pins.bank_select] =
                        pins.address_lines;
                end
            end
            sdi_pkg::SDI_PRECHARGE: begin
                if (pins.address_lines[`SDI_PRE_ALL_BIT]) begin
                    next_s.open = 4'h0;
                    if (s.ist == sdi_pkg::SDI_POWERUP) begin
                        next_s.ist = sdi_pkg::SDI_PREP;
                    end
                end else begin
                    next_s.open[pins.bank_select] = 1'b0;
                end
            end
            sdi_pkg::SDI_REFRESH: begin
                // count init refreshes, before or after mode load
                if (s.ist != sdi_pkg::SDI_READY
                    && s.ref_cnt != `SDI_INIT_REFRESH) begin
                    next_s.ref_cnt = s.ref_cnt + 2'h1;
                end
            end
            sdi_pkg::SDI_LOAD_MODE: begin
                // other bank codes address no register here
                if (pins.bank_select == `SDI_MODE_BANK) begin
                    next_s.mode = pins.address_lines;
                    next_s.mode_ok = 1'b1;
                end
            end
            default: ;
        endcase

        // ready once precharged, refreshed twice and mode loaded
        if (next_s.ist == sdi_pkg::SDI_PREP
            && next_s.ref_cnt == `SDI_INIT_REFRESH
            && next_s.mode_ok) begin
            next_s.ist = sdi_pkg::SDI_READY;
        end

        // latch burst parameters on a new access
        if (rw_go) begin
            next_s.b_wr    = wr_sel;
            next_s.b_bank  = bank_sel;
            next_s.b_start = start_sel;
            next_s.b_mask  = mask_sel;
            next_s.b_full  = full_sel;
            next_s.b_inter = inter_sel;
        end

        // one beat a cycle; a new read or write cuts the old burst
        if (rw_go || (s.burst_on && !halt)) begin
            next_s.acc.bank = bank_sel;
            next_s.acc.row  = s.row[bank_sel];
            next_s.acc.col  = beat_col;
            next_s.acc.rd   = !wr_sel;
            next_s.acc.wr   = wr_sel;
            next_s.b_cnt    = beat_sel + 11'h001;
            // full page runs until terminated
            next_s.burst_on = full_sel
                              || beat_sel != mask_sel;
        end else begin
            next_s.burst_on = 1'b0;
        end

        // outputs drive only during read beats, never after a load
        next_s.dq_oe = next_s.acc.rd;
        next_s.done  = next_s.ist == sdi_pkg::SDI_READY;
    end

    // single register stage; low clock enable freezes everything but reset
    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
            s.mode <= `SDI_MODE_RESET;
            s.org <= org_strap;
        end else if (clock_enable_input) begin
            s <= next_s;
        end
    end

    assign access     = s.acc;
    assign dq_oe      = s.dq_oe;
    assign mode_value = s.mode;
    assign banks_open = s.open;
    assign init_done  = s.done;

    // checks on the device behaviour
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (rst);

    freeze_cke_a: assert property (
        !clock_enable_input |=> $stable(s))
        else $error("state moved with clock enable low");

    act_row_a: assert property (
        clock_enable_input && cmd == sdi_pkg::SDI_ACTIVE
        && s.ist == sdi_pkg::SDI_READY
        |=> s.open[$past(pins.bank_select)]
            && s.row[$past(pins.bank_select)]
               == $past(pins.address_lines))
        else $error("active did not open the addressed row");

    pre_all_a: assert property (
        clock_enable_input && cmd == sdi_pkg::SDI_PRECHARGE
        && pins.address_lines[`SDI_PRE_ALL_BIT]
        |=> s.open == 4'h0 && !s.burst_on)
        else $error("precharge all left a bank open");

    pre_one_a: assert property (
        clock_enable_input && cmd == sdi_pkg::SDI_PRECHARGE
        && !pins.address_lines[`SDI_PRE_ALL_BIT]
        |=> !s.open[$past(pins.bank_select)]
            && ((s.open | $past(s.open)) == $past(s.open)))
        else $error("single precharge hit the wrong bank");

    lmr_load_a: assert property (
        clock_enable_input && cmd == sdi_pkg::SDI_LOAD_MODE
        && pins.bank_select == `SDI_MODE_BANK
        |=> s.mode == $past(pins.address_lines) && s.mode_ok)
        else $error("mode load did not store the op code");

    lmr_keep_a: assert property (
        cmd != sdi_pkg::SDI_LOAD_MODE
        || pins.bank_select != `SDI_MODE_BANK
        |=> s.mode == $past(s.mode))
        else $error("mode register changed without a load");

    hiz_lmr_a: assert property (
        clock_enable_input && cmd == sdi_pkg::SDI_LOAD_MODE
        |=> !dq_oe ##1 (!dq_oe || $past(rw_go)))
        else $error("outputs driven after mode load");

    col_start_a: assert property (
        clock_enable_input && rw_go
        |=> access.col == sdi_pkg::sdi_col_of(
                $past(pins.address_lines), s.org)
            && access.rd == $past(cmd == sdi_pkg::SDI_READ))
        else $error("first beat column is not the start column");

    blk_wrap_a: assert property (
        (access.rd || access.wr) && !s.b_full
        |-> (access.col & ~s.b_mask) == (s.b_start & ~s.b_mask))
        else $error("burst left its aligned block");

    page_wrap_a: assert property (
        clock_enable_input && s.burst_on && s.b_full && !halt
        && !rw_go && access.col == s.b_mask
        |=> access.col == 11'h000)
        else $error("full page burst did not wrap to column 0");

    len_bound_a: assert property (
        s.burst_on && !s.b_full |-> s.b_cnt <= s.b_mask)
        else $error("burst ran past its length");

    full_seq_a: assert property (
        s.b_full |-> !s.b_inter)
        else $error("full page burst used interleaved order");

    init_gate_a: assert property (
        access.rd || access.wr
        |-> s.mode_ok && s.ist == sdi_pkg::SDI_READY && init_done)
        else $error("access before initialisation finished");

    ready_hold_a: assert property (
        s.ist == sdi_pkg::SDI_READY |=> s.ist == sdi_pkg::SDI_READY)
        else $error("device left the ready state without reset");

    oe_read_a: assert property (
        dq_oe |-> access.rd && !access.wr)
        else $error("outputs driven outside a read beat");

    wbm_single_a: assert property (
        clock_enable_input && rw_go && cmd == sdi_pkg::SDI_WRITE
        && s.mode[`SDI_M_WBM]
        |=> access.wr && !s.burst_on)
        else $error("write burst mode did not force a single write");

    beat_addr_a: assert property (
        clock_enable_input && rw_go
        |=> access.bank == $past(pins.bank_select)
            && access.row == s.row[access.bank])
        else $error("beat went to the wrong bank or row");

    lmr_bank_a: assert property (
        clock_enable_input && cmd == sdi_pkg::SDI_LOAD_MODE
        && pins.bank_select != `SDI_MODE_BANK
        |=> s.mode_ok == $past(s.mode_ok))
        else $error("mode load to another bank counted as loaded");
endmodule

// ==== sdi_defines.svh ====
`ifndef SDI_DEFINES_SVH
`define SDI_DEFINES_SVH

// array geometry
`define SDI_BANK_W        2
`define SDI_ROW_W         12
`define SDI_COL_W         11
`define SDI_MODE_W        12

// mode register field positions
`define SDI_M_LEN_HI      2
`define SDI_M_LEN_LO      0
`define SDI_M_TYPE        3
`define SDI_M_LAT_HI      6
`define SDI_M_LAT_LO      4
`define SDI_M_OP_HI       8
`define SDI_M_OP_LO       7
`define SDI_M_WBM         9
`define SDI_MODE_RESET    12'h000

// burst length codes
`define SDI_BL1           3'h0
`define SDI_BL2           3'h1
`define SDI_BL4           3'h2
`define SDI_BL8           3'h3
`define SDI_BLFULL        3'h7

// column masks: block-of-n and whole row per organisation
`define SDI_MASK_BL1      11'h000
`define SDI_MASK_BL2      11'h001
`define SDI_MASK_BL4      11'h003
`define SDI_MASK_BL8      11'h007
`define SDI_MASK_X4       11'h7ff
`define SDI_MASK_X8       11'h3ff
`define SDI_MASK_X16      11'h1ff

// command pin codes {cs_n, ras_n, cas_n, we_n}
`define SDI_CMD_NOP       4'h7
`define SDI_CMD_ACTIVE    4'h3
`define SDI_CMD_READ      4'h5
`define SDI_CMD_WRITE     4'h4
`define SDI_CMD_TERM      4'h6
`define SDI_CMD_PRECHARGE 4'h2
`define SDI_CMD_REFRESH   4'h1
`define SDI_CMD_LOAD_MODE 4'h0

// misc
`define SDI_PRE_ALL_BIT   10
`define SDI_INIT_REFRESH  2'h2
`define SDI_MODE_BANK     2'h0

`endif

// ==== sdi_pkg.sv ====
package sdi_pkg;
`include "sdi_defines.svh"

    typedef enum logic [1:0] {SDI_X4, SDI_X8, SDI_X16} sdi_org_t;

    typedef enum logic [3:0] {
        SDI_INHIBIT, SDI_NOP, SDI_ACTIVE, SDI_READ, SDI_WRITE,
        SDI_TERM, SDI_PRECHARGE, SDI_REFRESH, SDI_LOAD_MODE
    } sdi_cmd_t;

    typedef enum logic [1:0] {SDI_POWERUP, SDI_PREP, SDI_READY} sdi_init_t;

    typedef struct packed {
        logic                   cs_n;
        logic                   ras_n;
        logic                   cas_n;
        logic                   we_n;
        logic [`SDI_BANK_W-1:0] bank_select;
        logic [`SDI_ROW_W-1:0]  address_lines;
    } sdi_pins_t;

    typedef struct packed {
        logic [`SDI_BANK_W-1:0] bank;
        logic [`SDI_ROW_W-1:0]  row;
        logic [`SDI_COL_W-1:0]  col;
        logic                   rd;
        logic                   wr;
    } sdi_access_t;

    typedef struct packed {
        sdi_init_t                    ist;
        logic [1:0]                   ref_cnt;
        logic                         mode_ok;
        logic [`SDI_MODE_W-1:0]       mode;
        logic [3:0]                   open;
        logic [3:0][`SDI_ROW_W-1:0]   row;
        sdi_org_t                     org;
        logic                         burst_on;
        logic                         b_wr;
        logic                         b_full;
        logic                         b_inter;
        logic [`SDI_BANK_W-1:0]       b_bank;
        logic [`SDI_COL_W-1:0]        b_start;
        logic [`SDI_COL_W-1:0]        b_mask;
        logic [`SDI_COL_W-1:0]        b_cnt;
        sdi_access_t                  acc;
        logic                         dq_oe;
        logic                         done;
    } sdi_state_t;

    function automatic sdi_cmd_t sdi_decode(sdi_pins_t p);
        sdi_cmd_t c;
        case ({p.cs_n, p.ras_n, p.cas_n, p.we_n})
            `SDI_CMD_NOP:       c = SDI_NOP;
            `SDI_CMD_ACTIVE:    c = SDI_ACTIVE;
            `SDI_CMD_READ:      c = SDI_READ;
            `SDI_CMD_WRITE:     c = SDI_WRITE;
            `SDI_CMD_TERM:      c = SDI_TERM;
            `SDI_CMD_PRECHARGE: c = SDI_PRECHARGE;
            `SDI_CMD_REFRESH:   c = SDI_REFRESH;
            `SDI_CMD_LOAD_MODE: c = SDI_LOAD_MODE;
            default:            c = SDI_INHIBIT;
        endcase
        return c;
    endfunction

    function automatic logic [`SDI_COL_W-1:0] sdi_row_mask(sdi_org_t o);
        case (o)
            SDI_X4:  return `SDI_MASK_X4;
            SDI_X8:  return `SDI_MASK_X8;
            default: return `SDI_MASK_X16;
        endcase
    endfunction

    // line 10 is the auto precharge flag, never a column bit
    function automatic logic [`SDI_COL_W-1:0] sdi_col_of(
        logic [`SDI_ROW_W-1:0] a, sdi_org_t o);
        case (o)
            SDI_X4:  return {a[11], a[9:0]};
            SDI_X8:  return {1'b0, a[9:0]};
            default: return {2'h0, a[8:0]};
        endcase
    endfunction

    // reserved length codes fall back to single access
    function automatic logic [`SDI_COL_W-1:0] sdi_blk_mask(
        logic [2:0] len, sdi_org_t o);
        case (len)
            `SDI_BL2:    return `SDI_MASK_BL2;
            `SDI_BL4:    return `SDI_MASK_BL4;
            `SDI_BL8:    return `SDI_MASK_BL8;
            `SDI_BLFULL: return sdi_row_mask(o);
            default:     return `SDI_MASK_BL1;
        endcase
    endfunction

endpackage

// ==== sdi_burst_col.sv ====
`timescale 1ns/100ps

// column of one burst beat inside its wrap block
module sdi_burst_col (
    // burst parameters
    input  wire logic [10:0] start,
    input  wire logic [10:0] beat,
    input  wire logic [10:0] mask,
    input  wire logic        inter,
    // resulting column
    output logic [10:0]      col
);
    logic [10:0] low;

    // bits above the mask stay fixed, so the burst wraps in its block
    always_comb begin
        low = inter ? (start ^ beat) : 11'(start + beat);
        col = (start & ~mask) | (low & mask);
    end
endmodule

// ==== sdi_ctrl_model.sv ====
`timescale 1ns/100ps
`include "sdi_defines.svh"

// stands in for the memory controller that drives the command pins
module sdi_ctrl_model #(
    parameter int WAIT_CYC = 1000, // 100us in 100ns cycles, exact
    parameter int PRE_GAP  = 2,
    parameter int RFC_GAP  = 7,
    parameter int MRD_GAP  = 2
) (
    // clock
    input  wire logic          clk,
    // pins toward the device
    output sdi_pkg::sdi_pins_t pins,
    output logic               clock_enable_input
);
    initial begin
        pins = sdi_pkg::sdi_pins_t'({4'hf, 2'h0, 12'h000});
        clock_enable_input = 1'b0; // low at power-up
    end

    // one command for one edge, then deselect with every line flipped,
    // so a stale address can never pass for a held one
    task automatic cmd(input logic [3:0] c, input logic [1:0] ba,
                       input logic [11:0] a, input int gap);
        @(posedge clk);
        pins <= sdi_pkg::sdi_pins_t'({c, ba, a});
        @(posedge clk);
        pins <= sdi_pkg::sdi_pins_t'({1'b1, ~c[2:0], ~ba, ~a});
        repeat (gap) @(posedge clk);
    endtask

    // command shown for one edge with clock enable low; must leave no trace
    task automatic held_cmd(input logic [3:0] c, input logic [1:0] ba,
                            input logic [11:0] a);
        @(posedge clk);
        clock_enable_input <= 1'b0;
        pins <= sdi_pkg::sdi_pins_t'({c, ba, a});
        @(posedge clk);
        clock_enable_input <= 1'b1;
        pins <= sdi_pkg::sdi_pins_t'({1'b1, ~c[2:0], ~ba, ~a});
        repeat (2) @(posedge clk);
    endtask

    // power-up wait under deselect, clock enable raised midway
    task automatic power_up();
        @(posedge clk);
        clock_enable_input <= 1'b0;
        repeat (WAIT_CYC / 2) @(posedge clk); // deselect only
        clock_enable_input <= 1'b1;
        repeat (WAIT_CYC - WAIT_CYC / 2) @(posedge clk);
    endtask

    // mode load always goes to bank 0 with every bank idle
    task automatic load_mode(input logic [11:0] md);
        cmd(`SDI_CMD_PRECHARGE, 2'h0, 12'h400, PRE_GAP);
        cmd(`SDI_CMD_LOAD_MODE, 2'h0, md, MRD_GAP);
    endtask

    // init: precharge all, two refreshes and a mode load in either order
    task automatic init_cmds(input logic [11:0] md, input bit lmr_first);
        cmd(`SDI_CMD_PRECHARGE, 2'h0, 12'h400, PRE_GAP);
        if (lmr_first) begin
            cmd(`SDI_CMD_LOAD_MODE, 2'h0, md, MRD_GAP);
        end
        repeat (2) begin
            cmd(`SDI_CMD_REFRESH, 2'h0, 12'h000, RFC_GAP);
        end
        if (!lmr_first) begin
            cmd(`SDI_CMD_LOAD_MODE, 2'h0, md, MRD_GAP);
        end
    endtask
endmodule

// ==== sdi_sdram_core_tb.sv ====
`timescale 1ns/100ps
`include "sdi_defines.svh"

module sdi_sdram_core_tb;
    logic                 clk;
    logic                 rst;
    sdi_pkg::sdi_org_t    org_strap;
    sdi_pkg::sdi_pins_t   pins;
    logic                 clock_enable_input;
    sdi_pkg::sdi_access_t access;
    logic                 dq_oe;
    logic [11:0]          mode_value;
    logic [3:0]           banks_open;
    logic                 init_done;
    int                   bad_count;
    int                   tests_run;
    int                   cycles;
    logic [13:0]          beats[$];
    localparam int LIMIT = 20000;

    sdi_ctrl_model sdi_ctrl_model_i (
        .clk                (clk),
        .pins               (pins),
        .clock_enable_input (clock_enable_input)
    );

    sdi_sdram_core sdi_sdram_core_i (
        .clk                (clk),
        .rst                (rst),
        .clock_enable_input (clock_enable_input),
        .org_strap          (org_strap),
        .pins               (pins),
        .access             (access),
        .dq_oe              (dq_oe),
        .mode_value         (mode_value),
        .banks_open         (banks_open),
        .init_done          (init_done)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask

    // beat log, output enable tied to read beats, hang guard
    always @(posedge clk) begin
        cycles++;
        if (access.rd === 1'b1 || access.wr === 1'b1) begin
            beats.push_back({access.wr, access.bank, access.col});
        end
        if (!rst && dq_oe !== access.rd) begin
            bad_count++;
            $display("[ERR] %0t output enable off read beats", $time);
        end
        if (cycles == LIMIT) begin
            bad_count++;
            $display("[ERR] %0t run did not finish", $time);
            end_of_test();
        end
    end

    task automatic do_reset(input sdi_pkg::sdi_org_t o);
        rst <= 1'b1;
        org_strap <= o;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
    endtask

    // issue one access and compare n beats against the wrap rule
    task automatic run_burst(input logic [3:0] c, input logic [1:0] ba,
                             input logic [11:0] a, input logic [10:0] s,
                             input int n, input bit inter);
        logic [10:0] m;
        logic [10:0] e;
        beats.delete();
        sdi_ctrl_model_i.cmd(c, ba, a, 12);
        m = 11'(n - 1);
        chk(16'(beats.size()), 16'(n), "beat count");
        for (int i = 0; i < n && i < beats.size(); i++) begin
            e = inter ? ((s & ~m) | ((s ^ 11'(i)) & m))
                      : ((s & ~m) | ((s + 11'(i)) & m));
            chk(16'(beats[i]), 16'({c == `SDI_CMD_WRITE, ba, e}),
                "beat");
        end
    endtask

    initial begin
        logic [11:0] md;
        logic [10:0] cmap [3];
        rst = 1'b1;
        org_strap = sdi_pkg::SDI_X4;
        bad_count = 0;
        tests_run = 0;
        cycles = 0;
        cmap = '{11'h7ff, 11'h3ff, 11'h1ff};
        for (int o = 0; o < 3; o++) begin
            do_reset(sdi_pkg::sdi_org_t'(o));
            @(posedge clk);
            chk(16'(mode_value), 16'h0000, "mode after reset");
            chk(16'(init_done), 16'h0000, "ready after reset");
            sdi_ctrl_model_i.power_up();
            sdi_ctrl_model_i.cmd(`SDI_CMD_ACTIVE, 2'h0, 12'h000, 2);
            chk(16'(banks_open), 16'h0000, "early activate");
            sdi_ctrl_model_i.init_cmds(12'h020, o == 0);
            chk(16'(init_done), 16'h0001, "ready");
            chk(16'(mode_value), 16'h0020, "mode loaded");
            sdi_ctrl_model_i.cmd(`SDI_CMD_LOAD_MODE, 2'h1, 12'h023, 2);
            chk(16'(mode_value), 16'h0020, "mode kept");
            sdi_ctrl_model_i.cmd(`SDI_CMD_ACTIVE, 2'h2, 12'ha5c, 2);
            chk(16'(banks_open), 16'h0004, "bank opened");
            run_burst(`SDI_CMD_READ, 2'h2, 12'hbff, cmap[o], 1, 0);
            chk(16'(access.row), 16'h0a5c, "row");
            $display("test width variant %0d done", o);
        end
        // lengths 1, 2, 4 and 8 with both orders, reads and writes
        for (int len = 0; len < 4; len++) begin
            for (int t = 0; t < 2; t++) begin
                md = {5'h00, 3'h2, t[0], len[2:0]}; // legal codes
                sdi_ctrl_model_i.load_mode(md);
                chk(16'(mode_value), 16'(md), "mode fields");
                sdi_ctrl_model_i.cmd(`SDI_CMD_ACTIVE, 2'h1, 12'h123,
                                     2);
                run_burst(`SDI_CMD_READ, 2'h1, 12'h00d, 11'h00d,
                          1 << len, t[0]);
                run_burst(`SDI_CMD_WRITE, 2'h1, 12'h00e, 11'h00e,
                          1 << len, t[0]);
            end
        end
        $display("test burst table done");
        // single writes, reads still burst
        sdi_ctrl_model_i.load_mode(12'h223);
        sdi_ctrl_model_i.cmd(`SDI_CMD_ACTIVE, 2'h1, 12'h040, 2);
        run_burst(`SDI_CMD_WRITE, 2'h1, 12'h005, 11'h005, 1, 0);
        run_burst(`SDI_CMD_READ, 2'h1, 12'h005, 11'h005, 8, 0);
        $display("test write burst mode done");
        // full page across the row end, cut short by terminate
        sdi_ctrl_model_i.load_mode(12'h027);
        sdi_ctrl_model_i.cmd(`SDI_CMD_ACTIVE, 2'h3, 12'h777, 2);
        beats.delete();
        sdi_ctrl_model_i.cmd(`SDI_CMD_READ, 2'h3, 12'h1fe, 4);
        sdi_ctrl_model_i.cmd(`SDI_CMD_TERM, 2'h0, 12'h000, 4);
        // terminate lands six edges after the read: six beats, no more
        chk(16'(beats.size()), 16'h0006, "page beats");
        for (int i = 0; i < 6 && i < beats.size(); i++) begin
            chk(16'(beats[i]), 16'({3'h3, 11'(11'h1fe + i) & 11'h1ff}),
                "page beat");
        end
        $display("test full page done");
        // single-bank precharge, then access to the closed bank
        sdi_ctrl_model_i.cmd(`SDI_CMD_ACTIVE, 2'h1, 12'h001, 2);
        chk(16'(banks_open), 16'h000a, "two banks open");
        sdi_ctrl_model_i.held_cmd(`SDI_CMD_PRECHARGE, 2'h0, 12'h400);
        chk(16'(banks_open), 16'h000a, "frozen precharge");
        sdi_ctrl_model_i.cmd(`SDI_CMD_PRECHARGE, 2'h1, 12'h000, 2);
        chk(16'(banks_open), 16'h0008, "one bank closed");
        run_burst(`SDI_CMD_READ, 2'h1, 12'h000, 11'h000, 0, 0);
        sdi_ctrl_model_i.cmd(`SDI_CMD_PRECHARGE, 2'h0, 12'h400, 2);
        chk(16'(banks_open), 16'h0000, "all closed");
        $display("test precharge scope done");
        end_of_test();
    end
endmodule
